//--- hdl/etac_top.v
// Elevator car tag alarm state machine
// Notes on behaviour
// - Detection field on only while the car door reads open.
// - Tag identified: hold door, flash keypad light, sound warning tone.
// - Tags gone or bypass within 11 s: stop light, tone, release door.
// - Tags still present after 11 s without bypass: enter full alarm.
// - New tag after bypass accepted: enter full alarm.
// - Full alarm: steady light, siren, door held until bypass or tags gone.
// - Bypass releases door hold so the car runs normally.
// - After bypass, door closing switches the field off.
// - Asset detach reports never change state, door hold or field.
// - Fire override releases the door hold.
// - Polarity jumper inverts the door sense input.
`timescale 1ns/10ps
`include "etac_consts.vh"
module etac_top
#(
  parameter TICK_CYC = `ETAC_CLK_HZ / 1000 * `ETAC_TICK_US / 1000,
  parameter PREALARM_MS = `ETAC_PREALARM_MS,
  parameter FLASH_HALF_MS = `ETAC_FLASH_HALF_MS,
  parameter ID_W = `ETAC_TAG_ID_W,
  parameter DEPTH = `ETAC_TAG_DEPTH
)
(
  input wire clk_i,
  input wire sys_rst_i,
  input wire door_closed_pin_i,
  input wire door_contact_polarity_jumper_i,
  input wire fire_override_pin_i,
  input wire tag_rpt_valid_i,
  input wire tag_rpt_kind_i,
  input wire [ID_W-1:0] tag_rpt_id_i,
  input wire tags_present_i,
  input wire bypass_ok_i,
  output reg field_enable_o,
  output reg door_hold_drive_out_o,
  output reg keypad_light_o,
  output reg keypad_tone_o,
  output reg siren_o,
  output reg [`ETAC_ST_W-1:0] state_o
);
  wire door_sense;
  wire jumper;
  wire fire;
  reg [`ETAC_ST_W-1:0] state_ff;
  reg [`ETAC_ST_W-1:0] nxt_state;
  reg [31:0] tick_cnt_ff;
  reg tick_ff;
  reg [31:0] pre_ms_ff;
  reg [31:0] flash_ms_ff;
  reg flash_ff;
  reg [ID_W-1:0] seen_id_ff [0:DEPTH-1];
  reg [DEPTH-1:0] seen_vld_ff;
  wire [DEPTH-1:0] hit;
  reg [31:0] wr_ptr_ff;
  wire door_open;
  wire presence;
  wire known;
  wire pre_done;

  etac_pin_sync #(.RESET_VAL(1'b1)) u_door
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(door_closed_pin_i),
    .level_o(door_sense)
  );

  etac_pin_sync #(.RESET_VAL(1'b0)) u_jump
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(door_contact_polarity_jumper_i),
    .level_o(jumper)
  );

  etac_pin_sync #(.RESET_VAL(1'b0)) u_fire
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(fire_override_pin_i),
    .level_o(fire)
  );

  // Sense high means closed unless the jumper flips it
  assign door_open = ~(door_sense ^ jumper);
  // Detach reports are filtered out here, before anything sees them
  assign presence = tag_rpt_valid_i &
    (tag_rpt_kind_i == `ETAC_KIND_PRESENCE);
  assign pre_done = (pre_ms_ff >= PREALARM_MS);

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : g_match
      // One driver per bit keeps the match vector single-sourced
      assign hit[g] = seen_vld_ff[g] & (seen_id_ff[g] == tag_rpt_id_i);
    end
  endgenerate
  assign known = |hit;

  // Millisecond tick; long counts kept as parameters for simulation
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tick_cnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end
    else if (tick_cnt_ff >= TICK_CYC - 1)
    begin
      tick_cnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `ETAC_ST_IDLE:
        if (door_open)
          nxt_state = `ETAC_ST_ARMED;
      `ETAC_ST_ARMED:
        if (!door_open)
          nxt_state = `ETAC_ST_IDLE;
        else if (presence)
          nxt_state = `ETAC_ST_PRE;
      `ETAC_ST_PRE:
        if (bypass_ok_i)
          nxt_state = `ETAC_ST_BYPASS;
        else if (!tags_present_i)
          nxt_state = `ETAC_ST_ARMED;
        else if (pre_done)
          nxt_state = `ETAC_ST_FULL;
      `ETAC_ST_FULL:
        if (bypass_ok_i)
          nxt_state = `ETAC_ST_BYPASS;
        else if (!tags_present_i)
          nxt_state = `ETAC_ST_ARMED;
      `ETAC_ST_BYPASS:
        if (!door_open)
          nxt_state = `ETAC_ST_IDLE;
        else if (presence && !known)
          nxt_state = `ETAC_ST_FULL;
      default:
        nxt_state = `ETAC_ST_IDLE;
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_ff <= `ETAC_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Pre-alarm timer runs only in pre-alarm
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pre_ms_ff <= 32'h0;
    else if (state_ff != `ETAC_ST_PRE)
      pre_ms_ff <= 32'h0;
    else if (tick_ff && !pre_done)
      pre_ms_ff <= pre_ms_ff + 32'h1;
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flash_ms_ff <= 32'h0;
      flash_ff <= 1'b0;
    end
    else if (state_ff != `ETAC_ST_PRE)
    begin
      flash_ms_ff <= 32'h0;
      flash_ff <= 1'b1;
    end
    else if (tick_ff)
    begin
      if (flash_ms_ff >= FLASH_HALF_MS - 1)
      begin
        flash_ms_ff <= 32'h0;
        flash_ff <= ~flash_ff;
      end
      else
        flash_ms_ff <= flash_ms_ff + 32'h1;
    end
  end

  // Tags seen since the door opened; a full table treats new ids as new
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      seen_vld_ff <= {DEPTH{1'b0}};
      wr_ptr_ff <= 32'h0;
    end
    else if (state_ff == `ETAC_ST_IDLE)
    begin
      seen_vld_ff <= {DEPTH{1'b0}};
      wr_ptr_ff <= 32'h0;
    end
    else if (presence && !known && wr_ptr_ff < DEPTH)
    begin
      seen_vld_ff[wr_ptr_ff] <= 1'b1;
      wr_ptr_ff <= wr_ptr_ff + 32'h1;
    end
  end

  always @(posedge clk_i)
  begin
    if (presence && !known && wr_ptr_ff < DEPTH)
      seen_id_ff[wr_ptr_ff] <= tag_rpt_id_i;
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      field_enable_o <= 1'b0;
      door_hold_drive_out_o <= 1'b0;
      keypad_light_o <= 1'b0;
      keypad_tone_o <= 1'b0;
      siren_o <= 1'b0;
      state_o <= `ETAC_ST_IDLE;
    end
    else
    begin
      field_enable_o <= door_open &&
        (state_ff != `ETAC_ST_IDLE);
      door_hold_drive_out_o <= !fire &&
        ((state_ff == `ETAC_ST_PRE) ||
         (state_ff == `ETAC_ST_FULL));
      keypad_light_o <= ((state_ff == `ETAC_ST_PRE) && flash_ff) ||
        (state_ff == `ETAC_ST_FULL);
      keypad_tone_o <= (state_ff == `ETAC_ST_PRE);
      siren_o <= (state_ff == `ETAC_ST_FULL);
      state_o <= state_ff;
    end
  end
endmodule

//--- shared/etac_consts.vh
// Constants for the elevator tag alarm controller
`ifndef ETAC_CONSTS_VH
`define ETAC_CONSTS_VH

`define ETAC_CLK_HZ 40000000
`define ETAC_TICK_US 1000
`define ETAC_PREALARM_MS 11000
`define ETAC_FLASH_HALF_MS 250
`define ETAC_TAG_ID_W 16
`define ETAC_TAG_DEPTH 8

`define ETAC_KIND_PRESENCE 1'h0
`define ETAC_KIND_DETACH 1'h1

`define ETAC_ST_W 3
`define ETAC_ST_IDLE 3'h0
`define ETAC_ST_ARMED 3'h1
`define ETAC_ST_PRE 3'h2
`define ETAC_ST_FULL 3'h3
`define ETAC_ST_BYPASS 3'h4

`endif

//--- hdl/etac_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module etac_pin_sync
#(
  parameter RESET_VAL = 1'b0
)
(
  input wire clk_i,
  input wire sys_rst_i,
  input wire pin_i,
  output reg level_o
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      level_o <= RESET_VAL;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Only a level seen on two later stages counts
      if (s2_ff == s3_ff)
        level_o <= s3_ff;
    end
  end
endmodule

//--- dv/etac_car_model.sv
// Car door contact and door-hold relay model
`timescale 1ns/10ps
module etac_car_model
(
  input wire open_req_i,
  input wire jumper_i,
  input wire hold_i,
  output wire door_closed_pin_o
);
  // A held door stays open whatever the car wants
  assign door_closed_pin_o = ~(open_req_i | hold_i) ^ jumper_i;
endmodule

//--- dv/etac_monitor.sv
// Port checker for the elevator tag alarm controller
`timescale 1ns/10ps
`include "etac_consts.vh"
module etac_monitor
#(
  parameter TICK_CYC = 4,
  parameter PREALARM_MS = 11,
  parameter FLASH_HALF_MS = 2
)
(
  input wire clk_i,
  input wire sys_rst_i,
  input wire field_enable_o,
  input wire door_hold_drive_out_o,
  input wire keypad_light_o,
  input wire keypad_tone_o,
  input wire siren_o,
  input wire [`ETAC_ST_W-1:0] state_o
);
  // Tick alignment adds up to one tick to each span
  localparam int LIM = PREALARM_MS * TICK_CYC + TICK_CYC + 2;
  localparam int FL = FLASH_HALF_MS * TICK_CYC + TICK_CYC;
  wire pre = state_o == `ETAC_ST_PRE;
  wire full = state_o == `ETAC_ST_FULL;
  wire hold = door_hold_drive_out_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_idle_quiet: assert property (
    state_o == `ETAC_ST_IDLE |-> !(field_enable_o | hold)) else $error("idle");
  // Field may drop in armed only as the door closes, idle follows
  a_armed_field: assert property (
    state_o == `ETAC_ST_ARMED && !field_enable_o |=>
      state_o == `ETAC_ST_IDLE) else $error("armed");
  a_pre_warn: assert property (
    pre |-> keypad_tone_o && !siren_o) else $error("pre tone");
  a_pre_flash: assert property (
    pre && keypad_light_o |-> ##[1:FL] (!keypad_light_o || !pre))
    else $error("no flash");
  a_hold_cause: assert property (
    hold |-> pre || full) else $error("hold");
  a_pre_bound: assert property (
    $rose(pre) |-> ##[1:LIM] !pre) else $error("pre too long");
  a_full_alarm: assert property (
    full |-> keypad_light_o && siren_o && !keypad_tone_o) else $error("full");
  a_byp_quiet: assert property (
    state_o == `ETAC_ST_BYPASS |-> !(hold | siren_o | keypad_light_o))
    else $error("bypass");
endmodule
bind etac_top etac_monitor #(.TICK_CYC(TICK_CYC), .PREALARM_MS(PREALARM_MS),
  .FLASH_HALF_MS(FLASH_HALF_MS)) i_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .field_enable_o(field_enable_o),
  .door_hold_drive_out_o(door_hold_drive_out_o),
  .keypad_light_o(keypad_light_o), .keypad_tone_o(keypad_tone_o),
  .siren_o(siren_o), .state_o(state_o));

//--- dv/test_etac_top.sv
// Scenario bench for the elevator tag alarm controller
`timescale 1ns/10ps
`include "etac_consts.vh"
module test_etac_top;
  reg clk_i = 1'b0, sys_rst_i = 1'b1, opn = 1'b0, jmp = 1'b0, fire = 1'b0;
  reg vld = 1'b0, kind = 1'b0, tp = 1'b0, byp = 1'b0;
  reg [`ETAC_TAG_ID_W-1:0] id = 16'h0000;
  wire pin, fld, hold, light, tone, siren;
  wire [`ETAC_ST_W-1:0] st;
  int errors = 0, compares = 0;
  always #12.5 clk_i = ~clk_i;
  etac_car_model i_car (.open_req_i(opn), .jumper_i(jmp), .hold_i(hold),
    .door_closed_pin_o(pin));
  etac_top #(.TICK_CYC(4), .PREALARM_MS(11), .FLASH_HALF_MS(2)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .door_closed_pin_i(pin),
    .door_contact_polarity_jumper_i(jmp), .fire_override_pin_i(fire),
    .tag_rpt_valid_i(vld), .tag_rpt_kind_i(kind), .tag_rpt_id_i(id),
    .tags_present_i(tp), .bypass_ok_i(byp), .field_enable_o(fld),
    .door_hold_drive_out_o(hold), .keypad_light_o(light),
    .keypad_tone_o(tone), .siren_o(siren), .state_o(st));
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input string n, input [2:0] e, input [2:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // One tag report or one bypass pulse, then settling time
  task pulse(input [`ETAC_TAG_ID_W-1:0] t, input k, input b);
    id = t;
    kind = k;
    {vld, byp} = {~b, b};
    cyc(1);
    {vld, byp} = 2'b00;
    cyc(3);
  endtask
  task s_bypass;
    opn = 1'b1;
    tp = 1'b1;
    cyc(8);
    chk("fld", 3'h1, fld);
    pulse(16'h0011, `ETAC_KIND_DETACH, 1'b0);
    chk("st", `ETAC_ST_ARMED, st);
    pulse(16'h0011, `ETAC_KIND_PRESENCE, 1'b0);
    chk("alarm", 3'h6, {hold, tone, siren});
    pulse(16'h0000, 1'b0, 1'b1);
    chk("st", `ETAC_ST_BYPASS, st);
    pulse(16'h0011, `ETAC_KIND_PRESENCE, 1'b0);
    chk("st", `ETAC_ST_BYPASS, st);
    pulse(16'h0022, `ETAC_KIND_PRESENCE, 1'b0);
    chk("st", `ETAC_ST_FULL, st);
    pulse(16'h0000, 1'b0, 1'b1);
    opn = 1'b0;
    cyc(8);
    chk("fld", 3'h0, fld);
  endtask
  task s_timeout;
    opn = 1'b1;
    cyc(8);
    pulse(16'h0033, `ETAC_KIND_PRESENCE, 1'b0);
    cyc(36);
    chk("st", `ETAC_ST_PRE, st);
    cyc(12);
    chk("alarm", 3'h7, {hold, light, siren});
    fire = 1'b1;
    cyc(8);
    chk("hold", 3'h0, hold);
    fire = 1'b0;
    tp = 1'b0;
    cyc(8);
    chk("alarm", 3'h0, {hold, light, siren});
  endtask
  task s_jumper;
    jmp = 1'b1;
    tp = 1'b1;
    cyc(10);
    chk("fld", 3'h1, fld);
    pulse(16'h0044, `ETAC_KIND_PRESENCE, 1'b0);
    tp = 1'b0;
    cyc(3);
    chk("alarm", 3'h0, {hold, tone, siren});
  endtask
  task summarize;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    sys_rst_i = 1'b0;
    s_bypass;
    s_timeout;
    s_jumper;
    summarize;
  end
  // Run needs about 140 cycles, so 2000 means a hang
  initial
  begin
    repeat (2000) @(negedge clk_i);
    errors++;
    summarize;
  end
endmodule
